// file: design/flash_cmd_front.sv
// Purpose: Command front end of a serial flash: framing, reset, identification and table reads.
// Assumes: Select, serial clock and data lanes are pins, sampled by two flip-flops each.
// Notes: Byte data comes from outside through the fetch request and fetch_data.
// Function
// - Opcode lanes follow protocol: one, two, four.
// - Width-dependent commands take four address bytes when addr4 is set, else three.
// - Configured dummy count used, not factory value.
// - General purpose register read: eight dummy cycles.
// - Beyond sixty-four register bytes, output zero.
// - Protected operations need prior write enable.
// - Reset needs arm then execute, separate selects.
// - Reset acts at select rise; host waits.
// - Reset reloads volatile settings from nonvolatile ones.
// - Reset aborts running or suspended array operation.
// - Reset done when flag bit seven reads one.
// - Arm refused during register write in progress.
// - Reset accepted in all lane and rate modes.
// - Identification opcodes shift out identification bytes.
// - Identification ignored during erase or program.
// - Select rise ends output, returns to standby.
// - Discovery read: address, then eight dummy clocks.
// - Discovery read always takes three address bytes.
// - Discovery output increments, wraps at 2048 bytes.
// - Discovery read ignores burst wrap setting.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_front (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic sel_n_pin, // Chip select pin, active low.
  input wire logic sck_pin, // Serial clock pin.
  input wire logic [3:0] dq_in_pin, // Data lanes, input side.
  output logic [3:0] dq_out, // Data lanes, output side.
  output logic [3:0] dq_oe, // Data lane output enables.
  input wire flash_cmd_pkg::cfg_t cfg, // Protocol configuration.
  input wire flash_cmd_pkg::busy_t busy, // Internal operation status.
  input wire logic wel, // Write enable latch.
  input wire logic [6:0] flag_low, // Low bits of the flag status.
  output flash_cmd_pkg::fetch_t fetch, // Byte fetch request.
  input wire logic [7:0] fetch_data, // Byte answering the fetch request.
  output flash_cmd_pkg::evt_t evt, // Event pulses.
  output logic [7:0] wp_opcode, // Opcode of the last protected command.
  output logic ready // Device ready after reset recovery.
);
  import flash_cmd_pkg::*;

  // Processing phase of the current select period.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_OPC = 6'h02, ST_ADDR = 6'h04, ST_DUMMY = 6'h08, ST_DATA = 6'h10,
    ST_SKIP = 6'h20
  } state_t;

  // Data bits moved per sampling edge.
  function automatic logic [2:0] lane_bits(input lane_mode_t m);
    unique case (m)
      LANE2: lane_bits = 3'h2;
      LANE4: lane_bits = 3'h4;
      default: lane_bits = 3'h1;
    endcase
  endfunction

  // Shifts the sampled lanes into the collector.
  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d,
                                           input lane_mode_t m);
    unique case (m)
      LANE2: shift_in = {s[29:0], d[1:0]};
      LANE4: shift_in = {s[27:0], d[3:0]};
      default: shift_in = {s[30:0], d[0]};
    endcase
  endfunction

  // Places the top bits of a byte on the lanes; one lane uses the second pin.
  function automatic logic [3:0] lane_out(input logic [7:0] b, input lane_mode_t m);
    unique case (m)
      LANE2: lane_out = {2'h0, b[7:6]};
      LANE4: lane_out = b[7:4];
      default: lane_out = {2'h0, b[7], 1'b0};
    endcase
  endfunction

  // Output enables for the active lane count.
  function automatic logic [3:0] lane_oe(input lane_mode_t m);
    unique case (m)
      LANE2: lane_oe = 4'h3;
      LANE4: lane_oe = 4'hf;
      default: lane_oe = 4'h2;
    endcase
  endfunction

  // True for commands that must find the write enable latch set.
  function automatic logic needs_wel(input logic [7:0] op);
    needs_wel = (op == OP_OTP_PROG) || (op == OP_PROT_PROG) || (op == OP_VLOCK_WR) ||
                (op == OP_NVLOCK_WR) || (op == OP_NVLOCK_ERASE) || (op == OP_FREEZE_WR) ||
                (op == OP_PASSWORD_WR) || (op == OP_VLOCK4_WR);
  endfunction

  // Pin synchronisers; only the second and third stages feed logic.
  logic sel_s1, sel_s2, sel_s3; // Select stages.
  logic sck_s1, sck_s2, sck_s3; // Serial clock stages.
  logic [3:0] dq_s1, dq_s2; // Data lane stages.

  // Two flip-flops per pin, plus a third stage on select and serial clock for edge detection.
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      dq_s1 <= 4'h0;
      dq_s2 <= 4'h0;
    end else begin
      sel_s1 <= sel_n_pin;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      sck_s1 <= sck_pin;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      dq_s1 <= dq_in_pin;
      dq_s2 <= dq_s1;
    end
  end

  logic selected; // Select is low.
  logic sel_rise; // Select has just gone high.
  logic sck_rise; // Serial clock rising edge.
  logic sck_fall; // Serial clock falling edge.
  logic in_ev; // Edge on which input bits are taken.
  logic out_ev; // Edge on which output bits change.
  logic [2:0] w; // Bits per edge.
  logic [31:0] sh_nx; // Collector after this edge.
  logic [5:0] bits_nx; // Bit count after this edge.
  logic [7:0] cur_byte; // Byte at the fetch address.

  // Edge detection; double rate takes bits on both edges.
  always_comb begin
    selected = !sel_s2;
    sel_rise = sel_s2 && !sel_s3;
    sck_rise = sck_s2 && !sck_s3;
    sck_fall = !sck_s2 && sck_s3;
    in_ev = selected && (sck_rise || (cfg.dtr && sck_fall));
    out_ev = selected && (sck_fall || (cfg.dtr && sck_rise));
    w = lane_bits(cfg.lanes);
  end

  // Working state of the interpreter.
  state_t state_q, state_d; // Phase.
  logic [31:0] sh_q, sh_d; // Input collector.
  logic [5:0] bits_q, bits_d; // Bits taken in this phase.
  logic [7:0] opcode_q, opcode_d; // Opcode of this select period.
  logic opc_ok_q, opc_ok_d; // A whole opcode has arrived.
  logic [2:0] abytes_q, abytes_d; // Address bytes expected.
  logic [3:0] dummy_q, dummy_d; // Dummy clocks expected.
  logic [3:0] dcnt_q, dcnt_d; // Dummy clocks seen.
  logic [7:0] ob_q, ob_d; // Output byte remainder.
  logic [3:0] obits_q, obits_d; // Output bits left in the byte.
  logic arm_q, arm_d; // Reset arm accepted.
  logic [15:0] rcnt_q, rcnt_d; // Recovery cycles left.
  logic ready_q, ready_d; // Ready flag.
  fetch_t fetch_q, fetch_d; // Fetch request.
  evt_t evt_q, evt_d; // Event pulses.
  logic [7:0] wp_op_q, wp_op_d; // Last protected opcode.
  logic [3:0] dq_out_q, dq_out_d; // Lane values.
  logic [3:0] dq_oe_q, dq_oe_d; // Lane enables.

  // Byte source; general purpose bytes past the end read as zero.
  always_comb begin
    sh_nx = shift_in(sh_q, dq_s2, cfg.lanes);
    bits_nx = bits_q + {3'h0, w};
    if (fetch_q.src == SRC_FLAG) begin
      cur_byte = {ready_q, flag_low};
    end else if (fetch_q.src == SRC_GP && fetch_q.addr >= GP_BYTES) begin
      cur_byte = 8'h00;
    end else begin
      cur_byte = fetch_data;
    end
  end

  // Next state of the interpreter.
  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    bits_d = bits_q;
    opcode_d = opcode_q;
    opc_ok_d = opc_ok_q;
    abytes_d = abytes_q;
    dummy_d = dummy_q;
    dcnt_d = dcnt_q;
    ob_d = ob_q;
    obits_d = obits_q;
    arm_d = arm_q;
    rcnt_d = rcnt_q;
    ready_d = ready_q;
    fetch_d = fetch_q;
    evt_d = '0;
    wp_op_d = wp_op_q;
    dq_out_d = dq_out_q;
    dq_oe_d = dq_oe_q;
    // Recovery count after a reset; the device stays busy meanwhile.
    if (!ready_q) begin
      rcnt_d = rcnt_q - 16'h0001;
      if (rcnt_q <= 16'h0001) begin
        ready_d = 1'b1;
      end
    end
    if (!selected) begin
      // Deselect ends every transfer and releases the lanes.
      state_d = ST_IDLE;
      dq_oe_d = 4'h0;
      opc_ok_d = 1'b0;
      if (sel_rise && opc_ok_q) begin
        // Command closes on the select rise.
        arm_d = 1'b0;
        if (opcode_q == OP_RST_ARM) begin
          arm_d = !(busy.sr_write || busy.nv_write);
        end else if (opcode_q == OP_RST_EXEC && arm_q) begin
          evt_d.reload = 1'b1;
          evt_d.abort = busy.wpe_active || busy.suspended;
          ready_d = 1'b0;
          rcnt_d = POST_RESET_CYC;
        end else if (needs_wel(opcode_q)) begin
          wp_op_d = opcode_q;
          evt_d.wp_exec = wel;
          evt_d.wp_refused = !wel;
        end
      end
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // New select period; busy recovery ignores it.
          state_d = ready_q ? ST_OPC : ST_SKIP;
          bits_d = 6'h00;
          dcnt_d = 4'h0;
          obits_d = 4'h0;
          fetch_d.src = SRC_NONE;
          fetch_d.addr = 32'h0;
        end
        ST_OPC: begin
          // Opcode arrives on the protocol's lanes.
          if (in_ev) begin
            sh_d = sh_nx;
            bits_d = bits_nx;
            if ({2'h0, bits_nx} == OPCODE_BITS) begin
              opcode_d = sh_nx[7:0];
              opc_ok_d = 1'b1;
              bits_d = 6'h00;
              state_d = ST_SKIP;
              if (sh_nx[7:0] == OP_ID_A || sh_nx[7:0] == OP_ID_B ||
                  sh_nx[7:0] == OP_ID_MULTI) begin
                if (!busy.wpe_active) begin
                  state_d = ST_DATA;
                  fetch_d.src = SRC_ID;
                end
                // Otherwise the command is skipped.
              end else if (sh_nx[7:0] == OP_DISC) begin
                state_d = ST_ADDR;
                abytes_d = ADDR_BYTES_3;
                dummy_d = FIXED_DUMMY;
                fetch_d.src = SRC_DISC;
              end else if (sh_nx[7:0] == OP_GP_READ) begin
                state_d = ST_DUMMY;
                dummy_d = FIXED_DUMMY;
                fetch_d.src = SRC_GP;
              end else if (sh_nx[7:0] == OP_FLAG_READ) begin
                state_d = ST_DATA;
                fetch_d.src = SRC_FLAG;
              end else if (sh_nx[7:0] == OP_OTP_READ || sh_nx[7:0] == OP_LOCK_READ) begin
                state_d = ST_ADDR;
                abytes_d = cfg.addr4 ? ADDR_BYTES_4 : ADDR_BYTES_3;
                dummy_d = (sh_nx[7:0] == OP_OTP_READ) ? cfg.dummy : 4'h0;
                fetch_d.src = SRC_EXT;
              end
            end
          end
        end
        ST_ADDR: begin
          // Address bytes, most significant first.
          if (in_ev) begin
            sh_d = sh_nx;
            bits_d = bits_nx;
            if (bits_nx == {abytes_q, 3'h0}) begin
              if (fetch_q.src == SRC_DISC) begin
                fetch_d.addr = {21'h0, sh_nx[10:0] & DISC_ADDR_MASK};
              end else if (abytes_q == ADDR_BYTES_4) begin
                fetch_d.addr = sh_nx;
              end else begin
                fetch_d.addr = {8'h00, sh_nx[23:0]};
              end
              state_d = (dummy_q == 4'h0) ? ST_DATA : ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          // Dummy clocks count rising edges only.
          if (sck_rise) begin
            dcnt_d = dcnt_q + 4'h1;
            if (dcnt_q + 4'h1 == dummy_q) begin
              state_d = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // Bytes shift out most significant bit first.
          if (out_ev) begin
            dq_oe_d = lane_oe(cfg.lanes);
            if (obits_q == 4'h0) begin
              dq_out_d = lane_out(cur_byte, cfg.lanes);
              ob_d = cur_byte << w;
              obits_d = 4'h8 - {1'b0, w};
              if (fetch_q.src == SRC_DISC) begin
                fetch_d.addr = {21'h0, fetch_q.addr[10:0] + 11'h001};
              end else if (fetch_q.src != SRC_GP || fetch_q.addr < GP_BYTES) begin
                fetch_d.addr = fetch_q.addr + 32'h1;
              end
            end else begin
              dq_out_d = lane_out(ob_q, cfg.lanes);
              ob_d = ob_q << w;
              obits_d = obits_q - {1'b0, w};
            end
          end
        end
        ST_SKIP: begin
          // Further clocks are ignored until deselect.
          state_d = ST_SKIP;
        end
      endcase
    end
  end

  // Registers of the interpreter.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      sh_q <= 32'h0;
      bits_q <= 6'h00;
      opcode_q <= 8'h00;
      opc_ok_q <= 1'b0;
      abytes_q <= 3'h0;
      dummy_q <= 4'h0;
      dcnt_q <= 4'h0;
      ob_q <= 8'h00;
      obits_q <= 4'h0;
      arm_q <= 1'b0;
      rcnt_q <= 16'h0000;
      ready_q <= 1'b1;
      fetch_q <= '0;
      evt_q <= '0;
      wp_op_q <= 8'h00;
      dq_out_q <= 4'h0;
      dq_oe_q <= 4'h0;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      opcode_q <= opcode_d;
      opc_ok_q <= opc_ok_d;
      abytes_q <= abytes_d;
      dummy_q <= dummy_d;
      dcnt_q <= dcnt_d;
      ob_q <= ob_d;
      obits_q <= obits_d;
      arm_q <= arm_d;
      rcnt_q <= rcnt_d;
      ready_q <= ready_d;
      fetch_q <= fetch_d;
      evt_q <= evt_d;
      wp_op_q <= wp_op_d;
      dq_out_q <= dq_out_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign fetch = fetch_q;
  assign evt = evt_q;
  assign wp_opcode = wp_op_q;
  assign ready = ready_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_gp_zero;
    (fetch_q.src == SRC_GP && fetch_q.addr >= GP_BYTES) |-> cur_byte == 8'h00;
  endproperty
  a_gp_zero: assert property (p_gp_zero) else $error("register byte past end not zero");

  property p_disc_wrap;
    (state_q == ST_DATA && fetch_q.src == SRC_DISC) |-> fetch_q.addr < 32'h0000_0800;
  endproperty
  a_disc_wrap: assert property (p_disc_wrap) else $error("table address beyond wrap");

  property p_reset_armed;
    evt_q.reload |-> $past(arm_q) && $past(opcode_q == OP_RST_EXEC) && $past(sel_rise);
  endproperty
  a_reset_armed: assert property (p_reset_armed) else $error("reset without arm");

  property p_arm_refused;
    (sel_rise && opc_ok_q && opcode_q == OP_RST_ARM && (busy.sr_write || busy.nv_write))
      |=> !arm_q;
  endproperty
  a_arm_refused: assert property (p_arm_refused) else $error("arm taken during write");

  property p_arm_clear;
    (sel_rise && opc_ok_q && opcode_q != OP_RST_ARM) |=> !arm_q;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm kept after other command");

  property p_id_busy;
    (state_q == ST_OPC && in_ev && busy.wpe_active && {2'h0, bits_nx} == OPCODE_BITS &&
     (sh_nx[7:0] == OP_ID_A || sh_nx[7:0] == OP_ID_B)) |=> state_q == ST_SKIP;
  endproperty
  a_id_busy: assert property (p_id_busy) else $error("identification decoded while busy");

  property p_deselect_release;
    !selected |=> dq_oe_q == 4'h0;
  endproperty
  a_deselect_release: assert property (p_deselect_release) else $error("lanes driven");

  property p_wel_check;
    (evt_q.wp_exec |-> $past(wel)) and (evt_q.wp_refused |-> !$past(wel));
  endproperty
  a_wel_check: assert property (p_wel_check) else $error("protected command misjudged");

  property p_abort_with_reset;
    evt_q.abort |-> evt_q.reload;
  endproperty
  a_abort_with_reset: assert property (p_abort_with_reset) else $error("abort alone");

  property p_recovery;
    evt_q.reload |-> !ready_q [*8];
  endproperty
  a_recovery: assert property (p_recovery) else $error("ready too soon after reset");
endmodule
`default_nettype wire

// file: inc/flash_cmd_pkg.sv
// Purpose: Shared constants and types for the serial flash command front end.
// Assumes: System clock of 10 MHz samples every pin of the serial link.
// Notes: Opcodes, fixed counts and pin/event bundles live here.
package flash_cmd_pkg;
  // System clock rate in MHz.
  localparam int CLK_MHZ = 10;
  // Opcodes decoded by the front end.
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RST_EXEC = 8'h99;
  localparam logic [7:0] OP_ID_A = 8'h9e;
  localparam logic [7:0] OP_ID_B = 8'h9f;
  localparam logic [7:0] OP_ID_MULTI = 8'haf;
  localparam logic [7:0] OP_DISC = 8'h5a;
  localparam logic [7:0] OP_GP_READ = 8'h96;
  localparam logic [7:0] OP_FLAG_READ = 8'h70;
  localparam logic [7:0] OP_OTP_READ = 8'h4b;
  localparam logic [7:0] OP_LOCK_READ = 8'he8;
  // Opcodes that need the write enable latch set beforehand.
  localparam logic [7:0] OP_OTP_PROG = 8'h42;
  localparam logic [7:0] OP_PROT_PROG = 8'h2c;
  localparam logic [7:0] OP_VLOCK_WR = 8'he5;
  localparam logic [7:0] OP_NVLOCK_WR = 8'he3;
  localparam logic [7:0] OP_NVLOCK_ERASE = 8'he4;
  localparam logic [7:0] OP_FREEZE_WR = 8'ha6;
  localparam logic [7:0] OP_PASSWORD_WR = 8'h28;
  localparam logic [7:0] OP_VLOCK4_WR = 8'he1;
  // Byte and cycle counts.
  localparam logic [7:0] OPCODE_BITS = 8'h08;
  localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
  localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
  localparam logic [3:0] FIXED_DUMMY = 4'h8;
  localparam logic [31:0] GP_BYTES = 32'h0000_0040;
  localparam logic [10:0] DISC_ADDR_MASK = 11'h7ff;
  localparam int FLAG_READY_BIT = 7;
  // Recovery time after a software reset, and its cycle count rounded up.
  localparam int POST_RESET_NS = 1000;
  localparam logic [15:0] POST_RESET_CYC = 16'((POST_RESET_NS * CLK_MHZ + 999) / 1000);
  // Lane count of the active protocol.
  typedef enum logic [1:0] {LANE1 = 2'h0, LANE2 = 2'h1, LANE4 = 2'h2} lane_mode_t;
  // Source of the bytes shifted out.
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_ID = 3'h1, SRC_DISC = 3'h2, SRC_GP = 3'h3, SRC_FLAG = 3'h4,
    SRC_EXT = 3'h5
  } src_t;
  // Protocol configuration from the configuration registers.
  typedef struct packed {
    lane_mode_t lanes;
    logic dtr;
    logic addr4;
    logic [3:0] dummy;
  } cfg_t;
  // Internal operation status from the array controller.
  typedef struct packed {
    logic wpe_active;
    logic suspended;
    logic sr_write;
    logic nv_write;
  } busy_t;
  // Byte fetch request toward the data sources.
  typedef struct packed {
    src_t src;
    logic [31:0] addr;
  } fetch_t;
  // One-cycle event pulses toward the rest of the device.
  typedef struct packed {
    logic reload;
    logic abort;
    logic wp_exec;
    logic wp_refused;
  } evt_t;
endpackage

// file: bench/host_spi_model.sv
// Purpose: Host controller model that frames commands on the serial link.
// Assumes: Link clock period of eight system clocks, single or double rate.
// Notes: Data is read just before each falling link edge.
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  input wire logic clock, // System clock used for pacing.
  input wire logic ddr, // Double rate: one bit group on every link edge.
  output logic sel_n, // Chip select, active low.
  output logic sck, // Link clock, still outside frames.
  output logic [3:0] dq, // Lanes toward the device.
  input wire logic [3:0] dq_out // Lanes from the device.
);
  // Deselect time kept between frames.
  localparam int DESELECT_CYC = 12;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    dq = 4'h0;
  end
  // Waits one half period of the link clock.
  task automatic half();
    repeat (4) @(posedge clock);
  endtask
  // Shifts a byte MSB first on one, two or four lanes; idle lanes toggle.
  task automatic put_byte(input logic [7:0] b, input int n);
    logic [7:0] v;
    v = b;
    for (int i = 0; i < 8 / n; i++) begin
      if (ddr) begin
        // Double rate: data moves halfway between edges, each edge takes it.
        repeat (2) @(posedge clock);
        dq <= (n == 4) ? v[7:4] : (n == 2) ? {~dq[3:2], v[7:6]} : {~dq[3:1], v[7]};
        v = v << n;
        repeat (2) @(posedge clock);
        sck <= ~sck;
      end else begin
        sck <= 1'b0;
        dq <= (n == 4) ? v[7:4] : (n == 2) ? {~dq[3:2], v[7:6]} : {~dq[3:1], v[7]};
        v = v << n;
        half();
        sck <= 1'b1;
        half();
      end
    end
  endtask
  // Dummy clocks with a changing pattern on the lanes.
  task automatic dummy(input int n);
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      dq <= ~dq;
      half();
      sck <= 1'b1;
      half();
    end
  endtask
  // Selects the device and sends the opcode.
  task automatic start(input logic [7:0] op, input int n);
    sel_n <= 1'b0;
    half();
    put_byte(op, n);
  endtask
  // Deselects and keeps the link quiet for the deselect time.
  task automatic stop();
    sck <= 1'b0;
    half();
    sel_n <= 1'b1;
    dq <= ~dq;
    repeat (DESELECT_CYC) @(posedge clock);
  endtask
  // Reads one byte from lane one.
  task automatic get_byte(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sck <= 1'b0;
      half();
      sck <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      b = {b[6:0], dq_out[1]};
      @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the command front end.
// Assumes: Bench answers design fetch requests with pattern data in the same cycle.
// Notes: Expected bytes come from a bench model of the table contents.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import flash_cmd_pkg::*;
  logic clock, rst, sel_n, sck, wel, ready;
  logic [3:0] dq, dq_out, dq_oe;
  logic [6:0] flag_low;
  logic [7:0] fetch_data, wp_opcode, b;
  cfg_t cfg;
  busy_t busy;
  fetch_t fetch;
  evt_t evt;
  int err_count, n_checks, seed, n_rel, n_abt, n_exe, n_ref, n_low, k;
  logic [31:0] ad;
  // Identification opcodes and protected opcodes walked by the scenarios.
  logic [7:0] id_ops [3] = '{OP_ID_A, OP_ID_B, OP_ID_MULTI};
  logic [7:0] wp_ops [8] = '{OP_OTP_PROG, OP_PROT_PROG, OP_VLOCK_WR, OP_NVLOCK_WR,
    OP_NVLOCK_ERASE, OP_FREEZE_WR, OP_PASSWORD_WR, OP_VLOCK4_WR};
  // Bench pattern for every byte source.
  function automatic logic [7:0] pat(input src_t s, input int a);
    return 8'(a) ^ {s, 5'h15};
  endfunction
  // Expected byte for a source and position.
  function automatic logic [7:0] model(input src_t s, input int a);
    if (s == SRC_FLAG) return {1'b1, flag_low};
    if (s == SRC_DISC) return pat(s, a % 2048);
    if (s == SRC_GP && a >= 64) return 8'h00;
    return pat(s, a);
  endfunction
  assign fetch_data = pat(fetch.src, int'(fetch.addr));
  flash_cmd_front flash_cmd_front_i (.clock(clock), .rst(rst), .sel_n_pin(sel_n),
    .sck_pin(sck), .dq_in_pin(dq), .dq_out(dq_out), .dq_oe(dq_oe), .cfg(cfg), .busy(busy),
    .wel(wel), .flag_low(flag_low), .fetch(fetch), .fetch_data(fetch_data), .evt(evt),
    .wp_opcode(wp_opcode), .ready(ready));
  host_spi_model host_spi_model_i (.clock(clock), .ddr(cfg.dtr), .sel_n(sel_n), .sck(sck),
    .dq(dq), .dq_out(dq_out));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Counts event pulses and recovery cycles once they have settled.
  always @(negedge clock) begin
    if (!rst) begin
      n_rel += int'(evt.reload);
      n_abt += int'(evt.abort);
      n_exe += int'(evt.wp_exec);
      n_ref += int'(evt.wp_refused);
      n_low += int'(ready === 1'b0);
    end
  end
  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Read command on one lane with address, dummy clocks and data bytes.
  task automatic rd(input logic [7:0] op, input int na, input logic [31:0] a, input int nd,
                    input src_t s, input int base, input int nb);
    host_spi_model_i.start(op, 1);
    for (int i = na - 1; i >= 0; i--) host_spi_model_i.put_byte(a[i*8+:8], 1);
    host_spi_model_i.dummy(nd);
    for (int i = 0; i < nb; i++) begin
      host_spi_model_i.get_byte(b);
      check(b, model(s, base + i));
    end
    check(dq_oe, 4'h2);
    host_spi_model_i.stop();
    check(dq_oe, 4'h0);
  endtask
  // Arm, optional other command, execute; then waits for recovery.
  task automatic rst_seq(input int n, input logic [7:0] mid, input int want);
    int r0, a0, l0, ab;
    r0 = n_rel;
    a0 = n_abt;
    l0 = n_low;
    host_spi_model_i.start(OP_RST_ARM, n);
    ab = (want != 0 && (busy.wpe_active || busy.suspended)) ? 1 : 0;
    host_spi_model_i.stop();
    if (mid != 8'h00) host_spi_model_i.start(mid, n);
    if (mid != 8'h00) host_spi_model_i.stop();
    host_spi_model_i.start(OP_RST_EXEC, n);
    host_spi_model_i.stop();
    for (k = 0; k < 200 && ready !== 1'b1; k++) @(posedge clock);
    if (k == 200) begin
      err_count++;
      print_verdict();
    end
    check(n_rel - r0, want);
    check(n_abt - a0, ab);
    check(n_low - l0, want * int'(POST_RESET_CYC));
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  initial begin
    seed = 33654;
    rst = 1'b1;
    cfg = '{LANE1, 1'b0, 1'b0, 4'h3};
    busy = '0;
    wel = 1'b0;
    flag_low = 7'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    foreach (id_ops[i]) rd(id_ops[i], 0, 0, 0, SRC_ID, 0, 3);
    busy <= '{1'b1, 1'b0, 1'b0, 1'b0};
    host_spi_model_i.start(OP_ID_B, 1);
    host_spi_model_i.get_byte(b);
    check(dq_oe, 4'h0);
    host_spi_model_i.stop();
    busy <= '0;
    ad = $random(seed);
    ad[10:0] = 11'h7fe;
    cfg <= '{LANE1, 1'b0, 1'b1, 4'h3};
    rd(OP_DISC, 3, {8'h00, ad[23:0]}, 8, SRC_DISC, int'(ad[10:0]), 3);
    rd(OP_OTP_READ, 4, ad, 3, SRC_EXT, int'(ad), 2);
    rd(OP_GP_READ, 0, 0, 8, SRC_GP, 0, 66);
    foreach (wp_ops[i]) begin
      wel <= 1'($random(seed));
      k = n_exe - n_ref;
      host_spi_model_i.start(wp_ops[i], 1);
      host_spi_model_i.stop();
      check(n_exe - n_ref - k, wel ? 1 : -1);
      check(wp_opcode, wp_ops[i]);
    end
    flag_low <= 7'($random(seed));
    rst_seq(1, 8'h00, 1);
    rd(OP_FLAG_READ, 0, 0, 0, SRC_FLAG, 0, 1);
    rst_seq(1, OP_ID_A, 0);
    busy <= '{1'b0, 1'b0, 1'b1, 1'b0};
    rst_seq(1, 8'h00, 0);
    busy <= '{1'b0, 1'b1, 1'b0, 1'b0};
    cfg <= '{LANE2, 1'b0, 1'b0, 4'h3};
    rst_seq(2, 8'h00, 1);
    busy <= '0;
    cfg <= '{LANE4, 1'b0, 1'b0, 4'h3};
    rst_seq(4, 8'h00, 1);
    cfg <= '{LANE2, 1'b1, 1'b0, 4'h3};
    rst_seq(2, 8'h00, 1);
    cfg <= '{LANE1, 1'b0, 1'b0, 4'h3};
    rd(OP_FLAG_READ, 0, 0, 0, SRC_FLAG, 0, 1);
    print_verdict();
  end
endmodule
`default_nettype wire
